/* File: design/sisr_consts.svh */
// constants of the servo input signal router: offsets, fields, reset values
// assumes inclusion by the package, the top module, the monitor and the testbench
// Functional notes
// - either hard cutoff request input OFF cuts motor current, no command can override
// - monitor output ON only when both requests cut off and drive is cut off
// - selector digit of functions 0-4: 0-6 terminal, 7 always active, 8 always inactive
// - latch selectors route only terminals 4-6 or inverted D-F, else inactive
// - one terminal selected by several functions drives all of them at once
// - selectors are writable; reset values 1, 2, 8, 8 and 3, 4, 5, 6
`ifndef SISR_CONSTS_SVH
`define SISR_CONSTS_SVH

// wishbone register offsets (byte addresses)
`define SISR_ADR_W 8
`define SISR_ADR_SEL_A 8'h00
`define SISR_ADR_SEL_B 8'h04
`define SISR_ADR_STATUS 8'h08
`define SISR_ADR_IRQ_STAT 8'h0C
`define SISR_ADR_IRQ_MASK 8'h10

// selector reset values, one nibble per function
`define SISR_SEL_A_RST 16'h8821
`define SISR_SEL_B_RST 16'h6543
`define SISR_MASK_RST 9'h000

// sizes
`define SISR_SEL_W 4
`define SISR_NUM_FUNC 8
`define SISR_NUM_TERM 7
`define SISR_NUM_EV 9

// status and interrupt field positions
`define SISR_ST_FUNC_LSB 0
`define SISR_ST_CUTOFF_BIT 8
`define SISR_ST_MON_BIT 9
`define SISR_ST_TERM_LSB 16
`define SISR_EV_CUTOFF_BIT 8

// selector encodings
`define SISR_SEL_LAST_NORM 4'h6
`define SISR_SEL_ALWAYS_ON 4'h7
`define SISR_SEL_ALWAYS_OFF 4'h8
`define SISR_SEL_INV_BASE 4'h9
`define SISR_SEL_LATCH_FIRST 4'h4
`define SISR_SEL_LATCH_INV_FIRST 4'hD

// per-function polarity and latch restriction, bit i is function i
`define SISR_LOW_ACTIVE 8'hFC
`define SISR_LATCH_ONLY 8'hE0

`endif

/* File: design/sisr_pkg.sv */
// types and the selector decode shared by the router modules
// assumes sisr_consts.svh on the include path
`include "sisr_consts.svh"

package sisr_pkg;

    typedef logic [`SISR_SEL_W-1:0] sisr_sel_t;
    typedef logic [`SISR_NUM_TERM-1:0] sisr_term_t;

    // state of one routing slice
    typedef struct packed {
        logic active;
    } sisr_route_st_t;

    // state of the top module
    typedef struct packed {
        logic [15:0] sel_a;
        logic [15:0] sel_b;
        logic [`SISR_NUM_EV-1:0] mask;
        logic [`SISR_NUM_EV-1:0] pend;
        logic [`SISR_NUM_FUNC-1:0] func_prev;
        logic cutoff;
        logic monitor;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } sisr_top_st_t;

    // function level from selector digit, synced terminals and polarity
    function automatic logic sisr_route_level(input sisr_sel_t sel, input sisr_term_t term,
                                              input logic low_act, input logic latch_only);
        logic lvl;
        lvl = 1'b0;
        if (latch_only) begin
            if (sel >= `SISR_SEL_LATCH_FIRST && sel <= `SISR_SEL_LAST_NORM) begin
                lvl = term[sel[2:0]] ^ low_act;
            end else if (sel >= `SISR_SEL_LATCH_INV_FIRST) begin
                lvl = ~(term[3'(sel - `SISR_SEL_INV_BASE)] ^ low_act);
            end
        end else if (sel <= `SISR_SEL_LAST_NORM) begin
            lvl = term[sel[2:0]] ^ low_act;
        end else if (sel == `SISR_SEL_ALWAYS_ON) begin
            lvl = 1'b1;
        end else if (sel >= `SISR_SEL_INV_BASE) begin
            lvl = ~(term[3'(sel - `SISR_SEL_INV_BASE)] ^ low_act);
        end
        return lvl;
    endfunction

endpackage

/* File: design/sisr_term_if.sv */
// carrier of the synchronised terminal levels between router modules
// assumes one source and any number of readers on the same clock
`timescale 1ns/1ps

interface sisr_term_if;
    logic [6:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

/* File: design/sisr_sync.sv */
// two flip-flop synchroniser for a group of pin levels
// assumes pins asynchronous to clk_i; reset value is a parameter
`timescale 1ns/1ps

module sisr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // pins and sampled levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sisr_sync_st_t;

    sisr_sync_st_t st;
    sisr_sync_st_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{s1: RST_VAL, s2: RST_VAL};
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o = st.s2;

endmodule

/* File: design/sisr_route.sv */
// one routing slice: selector digit picks a terminal, polarity or constant
// assumes terminals already synchronised and selector from the same clock
`timescale 1ns/1ps

module sisr_route
    import sisr_pkg::*;
#(
    parameter logic LOW_ACT = 1'b0,
    parameter logic LATCH_ONLY = 1'b0
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // selector and terminals
    input wire sisr_sel_t sel_i,
    sisr_term_if.dst term,
    // routed function, 1 = active
    output logic active_o
);

    sisr_route_st_t st;
    sisr_route_st_t next_st;

    // every slice reads the shared terminal bus, so sharing drives all
    always_comb begin
        next_st.active = sisr_route_level(sel_i, term.level, LOW_ACT, LATCH_ONLY);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{active: 1'b0};
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign active_o = st.active;

endmodule

/* File: design/sisr_top.sv */
// servo input signal router: wishbone registers, terminal routing,
// hard cutoff of motor current and its monitor output
// assumes classic wishbone master on clk_i; pins asynchronous to clk_i
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "sisr_consts.svh"

module sisr_top
    import sisr_pkg::*;
#(
    parameter logic [15:0] SEL_A_RST = `SISR_SEL_A_RST,
    parameter logic [15:0] SEL_B_RST = `SISR_SEL_B_RST,
    parameter logic [`SISR_NUM_FUNC-1:0] LOW_ACTIVE = `SISR_LOW_ACTIVE,
    parameter logic [`SISR_NUM_FUNC-1:0] LATCH_ONLY = `SISR_LATCH_ONLY
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SISR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sequence input terminals, 1 = high level at the pin
    input wire logic [`SISR_NUM_TERM-1:0] seq_term_i,
    // hard cutoff requests from the safety connector, low = OFF
    input wire logic hard_cutoff_req_a_n_i,
    input wire logic hard_cutoff_req_b_n_i,
    // routed functions, 1 = active
    output logic fwd_travel_block_o,
    output logic rev_travel_block_o,
    output logic fwd_force_limit_in_o,
    output logic rev_force_limit_in_o,
    output logic home_decel_switch_o,
    output logic latch_trig_1_o,
    output logic latch_trig_2_o,
    output logic latch_trig_3_o,
    // motor current and safety monitor
    output logic motor_current_en_o,
    output logic cutoff_monitor_out_o,
    // interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [`SISR_NUM_TERM-1:0] term_sync;
    logic [1:0] cut_n_sync;

    // terminals sampled twice before any routing
    sisr_sync #(
        .W(`SISR_NUM_TERM),
        .RST_VAL('0)
    ) u_term_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(seq_term_i),
        .q_o(term_sync)
    );

    // cutoff requests reset to OFF so the drive starts cut off
    sisr_sync #(
        .W(2),
        .RST_VAL(2'h0)
    ) u_cut_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({hard_cutoff_req_b_n_i, hard_cutoff_req_a_n_i}),
        .q_o(cut_n_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // terminal routing

    sisr_term_if term_bus ();

    // one shared bus of synced levels
    assign term_bus.level = term_sync;

    sisr_top_st_t st;
    sisr_top_st_t next_st;
    logic [`SISR_NUM_FUNC*`SISR_SEL_W-1:0] sel_all;
    logic [`SISR_NUM_FUNC-1:0] func;

    // selector digits in function order
    assign sel_all = {st.sel_b, st.sel_a};

    // one slice per function, each with its own polarity
    for (genvar i = 0; i < `SISR_NUM_FUNC; i++) begin : g_route
        sisr_route #(
            .LOW_ACT(LOW_ACTIVE[i]),
            .LATCH_ONLY(LATCH_ONLY[i])
        ) u_route (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .sel_i(sel_all[i*`SISR_SEL_W +: `SISR_SEL_W]),
            .term(term_bus.dst),
            .active_o(func[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file, cutoff and interrupt logic

    logic req;
    logic wr;
    logic rd_irq;
    logic cut_now;
    logic both_off;
    logic [`SISR_NUM_EV-1:0] ev;
    logic [`SISR_NUM_EV-1:0] clr;
    logic [31:0] rd_word;

    // bus request decode
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~st.ack;
        wr = req & wb_we_i;
        rd_irq = req & ~wb_we_i & (wb_adr_i == `SISR_ADR_IRQ_STAT);
    end

    // cutoff state from the synced request pins
    always_comb begin
        cut_now = ~(cut_n_sync[0] & cut_n_sync[1]);
        both_off = ~cut_n_sync[0] & ~cut_n_sync[1];
    end

    // events: function rising edges and entry into cutoff
    always_comb begin
        ev = '0;
        ev[`SISR_NUM_FUNC-1:0] = func & ~st.func_prev;
        ev[`SISR_EV_CUTOFF_BIT] = cut_now & ~st.cutoff;
        clr = rd_irq ? '1 : '0;
    end

    // read data multiplexer, unmapped reads as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            `SISR_ADR_SEL_A: begin
                rd_word[15:0] = st.sel_a;
            end
            `SISR_ADR_SEL_B: begin
                rd_word[15:0] = st.sel_b;
            end
            `SISR_ADR_STATUS: begin
                rd_word[`SISR_ST_FUNC_LSB +: `SISR_NUM_FUNC] = func;
                rd_word[`SISR_ST_CUTOFF_BIT] = st.cutoff;
                rd_word[`SISR_ST_MON_BIT] = st.monitor;
                rd_word[`SISR_ST_TERM_LSB +: `SISR_NUM_TERM] = term_sync;
            end
            `SISR_ADR_IRQ_STAT: begin
                rd_word[`SISR_NUM_EV-1:0] = st.pend;
            end
            `SISR_ADR_IRQ_MASK: begin
                rd_word[`SISR_NUM_EV-1:0] = st.mask;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // next state of the whole top
    always_comb begin
        next_st = st;
        // single-cycle registered acknowledge
        next_st.ack = req;
        if (req) begin
            next_st.rdat = rd_word;
        end
        // selector writes per byte lane
        if (wr && wb_adr_i == `SISR_ADR_SEL_A) begin
            if (wb_sel_i[0]) begin
                next_st.sel_a[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_st.sel_a[15:8] = wb_dat_i[15:8];
            end
        end
        if (wr && wb_adr_i == `SISR_ADR_SEL_B) begin
            if (wb_sel_i[0]) begin
                next_st.sel_b[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_st.sel_b[15:8] = wb_dat_i[15:8];
            end
        end
        // mask write
        if (wr && wb_adr_i == `SISR_ADR_IRQ_MASK) begin
            if (wb_sel_i[0]) begin
                next_st.mask[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                next_st.mask[8] = wb_dat_i[8];
            end
        end
        // sticky events, a new event wins over the read clear
        next_st.pend = (st.pend & ~clr) | ev;
        next_st.func_prev = func;
        // cutoff follows the pins with no software path
        next_st.cutoff = cut_now;
        // monitor needs both requests and the drive already cut off
        next_st.monitor = both_off & st.cutoff;
        next_st.irq = |(next_st.pend & next_st.mask);
    end

    // state register; reset keeps motor current off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.sel_a <= SEL_A_RST;
            st.sel_b <= SEL_B_RST;
            st.mask <= `SISR_MASK_RST;
            st.pend <= '0;
            st.func_prev <= '1; // no edge in the first cycle after reset; refill edges still set pend
            st.cutoff <= 1'b1;
            st.monitor <= 1'b0;
            st.irq <= 1'b0;
            st.ack <= 1'b0;
            st.rdat <= 32'h0000_0000;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // bus answer
    assign wb_dat_o = st.rdat;
    assign wb_ack_o = st.ack;

    // routed functions
    assign fwd_travel_block_o = func[0];
    assign rev_travel_block_o = func[1];
    assign fwd_force_limit_in_o = func[2];
    assign rev_force_limit_in_o = func[3];
    assign home_decel_switch_o = func[4];
    assign latch_trig_1_o = func[5];
    assign latch_trig_2_o = func[6];
    assign latch_trig_3_o = func[7];

    // safety outputs
    assign motor_current_en_o = ~st.cutoff;
    assign cutoff_monitor_out_o = st.monitor;

    // level interrupt from registered status and mask
    assign irq_o = st.irq;

endmodule

/* File: testbench/sisr_monitor.sv */
// checker of the input router: routing, cutoff and monitor timing
// assumes ce_i high; selector shadows follow the byte lanes
`timescale 1ns/1ps
`include "sisr_consts.svh"

module sisr_monitor #(
    parameter logic [15:0] SEL_A_RST = `SISR_SEL_A_RST,
    parameter logic [15:0] SEL_B_RST = `SISR_SEL_B_RST
) (
    // clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SISR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins and functions
    input wire logic [`SISR_NUM_TERM-1:0] seq_term_i,
    input wire logic hard_cutoff_req_a_n_i,
    input wire logic hard_cutoff_req_b_n_i,
    input wire logic fwd_travel_block_o,
    input wire logic rev_travel_block_o,
    input wire logic fwd_force_limit_in_o,
    input wire logic rev_force_limit_in_o,
    input wire logic home_decel_switch_o,
    input wire logic latch_trig_1_o,
    input wire logic motor_current_en_o,
    input wire logic cutoff_monitor_out_o
);
    logic [15:0] sa;
    logic [15:0] sb;
    logic [6:0] t1;
    logic [6:0] t2;
    logic [6:0] t3;
    logic [2:0] qt;
    logic tk;
    logic ok;
    assign tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign ok = qt >= 3'h4;
    // shadow selectors, pin delay line, cycles since a write
    always_ff @(posedge clk_i) begin
        t1 <= seq_term_i;
        t2 <= t1;
        t3 <= t2;
        if (rst_i) begin
            sa <= SEL_A_RST;
            sb <= SEL_B_RST;
            qt <= 3'h0;
        end else begin
            qt <= tk ? 3'h0 : (qt == 3'h7 ? qt : qt + 3'h1);
            if (tk && wb_adr_i == `SISR_ADR_SEL_A && wb_sel_i[0]) sa[7:0] <= wb_dat_i[7:0];
            if (tk && wb_adr_i == `SISR_ADR_SEL_A && wb_sel_i[1]) sa[15:8] <= wb_dat_i[15:8];
            if (tk && wb_adr_i == `SISR_ADR_SEL_B && wb_sel_i[0]) sb[7:0] <= wb_dat_i[7:0];
            if (tk && wb_adr_i == `SISR_ADR_SEL_B && wb_sel_i[1]) sb[15:8] <= wb_dat_i[15:8];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    sequence s_both; (!hard_cutoff_req_a_n_i && !hard_cutoff_req_b_n_i) [*5]; endsequence
    sequence s_one; !(hard_cutoff_req_a_n_i && hard_cutoff_req_b_n_i); endsequence
    property p_cut; s_one |-> ##3 !motor_current_en_o; endproperty
    property p_mon_on; s_both |-> cutoff_monitor_out_o; endproperty
    property p_mon_off; hard_cutoff_req_a_n_i [*5] |-> !cutoff_monitor_out_o; endproperty
    property p_ftrav; ok && sa[3:0] <= 4'h6 |-> fwd_travel_block_o == t3[sa[2:0]]; endproperty
    property p_fforce;
        ok && sa[11:8] >= 4'h9 |-> fwd_force_limit_in_o == t3[3'(sa[11:8] - 4'h9)];
    endproperty
    property p_rforce;
        ok && sa[15:12] <= 4'h6 |-> rev_force_limit_in_o != t3[sa[14:12]];
    endproperty
    property p_latch;
        ok && (sb[7:4] < 4'h4 || (sb[7:4] > 4'h6 && sb[7:4] < 4'hD)) |-> !latch_trig_1_o;
    endproperty
    property p_share;
        ok && sa[3:0] == sa[7:4] && sa[3:0] <= 4'h6 |-> fwd_travel_block_o == rev_travel_block_o;
    endproperty
    property p_home; ok && sb[3:0] <= 4'h6 |-> home_decel_switch_o != t3[sb[2:0]]; endproperty
    a_cut: assert property (p_cut) else $error("current not cut");
    a_mon_on: assert property (p_mon_on) else $error("monitor not on");
    a_mon_off: assert property (p_mon_off) else $error("monitor on early");
    a_ftrav: assert property (p_ftrav) else $error("travel route");
    a_fforce: assert property (p_fforce) else $error("force inverted");
    a_rforce: assert property (p_rforce) else $error("force low");
    a_latch: assert property (p_latch) else $error("latch routed");
    a_share: assert property (p_share) else $error("shared pin");
    a_home: assert property (p_home) else $error("decel route");
endmodule

bind sisr_top sisr_monitor #(.SEL_A_RST(SEL_A_RST), .SEL_B_RST(SEL_B_RST)) sisr_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .seq_term_i(seq_term_i),
    .hard_cutoff_req_a_n_i(hard_cutoff_req_a_n_i), .hard_cutoff_req_b_n_i(hard_cutoff_req_b_n_i),
    .fwd_travel_block_o(fwd_travel_block_o), .rev_travel_block_o(rev_travel_block_o),
    .fwd_force_limit_in_o(fwd_force_limit_in_o), .rev_force_limit_in_o(rev_force_limit_in_o),
    .home_decel_switch_o(home_decel_switch_o), .latch_trig_1_o(latch_trig_1_o),
    .motor_current_en_o(motor_current_en_o), .cutoff_monitor_out_o(cutoff_monitor_out_o));

/* File: testbench/sisr_field_model.sv */
// field side: limit switches, latch sensors, safety contacts
// assumes commands change just after clk_i edges
`timescale 1ns/1ps

module sisr_field_model (
    // clock and commands
    input wire logic clk_i,
    input wire logic [6:0] sw_cmd_i,
    input wire logic safe_a_on_i,
    input wire logic safe_b_on_i,
    // pin levels
    output logic [6:0] seq_term_o = 7'h00,
    output logic req_a_n_o = 1'b0,
    output logic req_b_n_o = 1'b0
);
    // contacts follow one cycle late; wiring kept to factory polarity
    always @(posedge clk_i) begin
        seq_term_o <= sw_cmd_i;
        req_a_n_o <= safe_a_on_i;
        req_b_n_o <= safe_b_on_i;
    end
endmodule

/* File: testbench/testbench.sv */
// bench of the input router: registers, routing, cutoff, interrupt
// assumes design and field model compiled first
`timescale 1ns/1ps
`include "sisr_consts.svh"

module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] bsel = 4'hF;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [6:0] sw = 7'h00;
    logic sa_on = 1'b0;
    logic sb_on = 1'b0;
    logic [6:0] term;
    logic rqa;
    logic rqb;
    logic ack;
    logic irq;
    logic men;
    logic mon;
    logic [7:0] fn;
    int fails = 0;
    int samples_checked = 0;
    logic [15:0] ta [5] = '{16'h8821, 16'h790A, 16'h790A, 16'h5066, 16'h5066};
    logic [15:0] tb [5] = '{16'h6543, 16'hF3DC, 16'hF3DC, 16'hC708, 16'hC708};
    logic [6:0] tp [5] = '{7'h02, 7'h59, 7'h26, 7'h7F, 7'h00};
    logic [7:0] tf [5] = '{8'hF1, 8'hBF, 8'h08, 8'h03, 8'h0C};

    sisr_field_model sisr_field_model_inst (.clk_i(clk_i), .sw_cmd_i(sw), .safe_a_on_i(sa_on),
        .safe_b_on_i(sb_on), .seq_term_o(term), .req_a_n_o(rqa), .req_b_n_o(rqb));
    sisr_top sisr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .seq_term_i(term), .hard_cutoff_req_a_n_i(rqa),
        .hard_cutoff_req_b_n_i(rqb), .fwd_travel_block_o(fn[0]), .rev_travel_block_o(fn[1]),
        .fwd_force_limit_in_o(fn[2]), .rev_force_limit_in_o(fn[3]),
        .home_decel_switch_o(fn[4]), .latch_trig_1_o(fn[5]), .latch_trig_2_o(fn[6]),
        .latch_trig_3_o(fn[7]), .motor_current_en_o(men), .cutoff_monitor_out_o(mon),
        .irq_o(irq));

    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, bounded wait for ack
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            chk(32'h0, 32'h1);
            end_of_test;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped place
        rd(`SISR_ADR_SEL_A, 32'h8821);
        rd(`SISR_ADR_SEL_B, 32'h6543);
        rd(8'h40, 32'h0);
        rd(`SISR_ADR_IRQ_MASK, 32'h0);
        $display("test reset done");
        // routing table
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, `SISR_ADR_SEL_A, {16'h0, ta[i]});
            xfer(1'b1, `SISR_ADR_SEL_B, {16'h0, tb[i]});
            sw <= tp[i];
            repeat (6) @(posedge clk_i);
            chk({24'h0, fn}, {24'h0, tf[i]});
        end
        rd(`SISR_ADR_STATUS, 32'h030C);
        $display("test routing done");
        // every safety contact combination
        for (int i = 0; i < 4; i++) begin
            sa_on <= i[1];
            sb_on <= i[0];
            repeat (7) @(posedge clk_i);
            chk({30'h0, men, mon}, {30'h0, i[1] & i[0], ~i[1] & ~i[0]});
        end
        $display("test cutoff done");
        // interrupt raised, cleared, masked
        xfer(1'b0, `SISR_ADR_IRQ_STAT, 32'h0);
        xfer(1'b1, `SISR_ADR_IRQ_MASK, 32'h1);
        sw <= 7'h40;
        repeat (6) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        rd(`SISR_ADR_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, `SISR_ADR_IRQ_MASK, 32'h100);
        sw <= 7'h00;
        repeat (6) @(posedge clk_i);
        sw <= 7'h40;
        repeat (6) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        sa_on <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        rd(`SISR_ADR_IRQ_STAT, 32'h103);
        $display("test interrupt done");
        // byte lanes: only lane 1 of the latch selectors is written
        bsel <= 4'h2;
        xfer(1'b1, `SISR_ADR_SEL_B, 32'h0000_4500);
        bsel <= 4'hF;
        rd(`SISR_ADR_SEL_B, 32'h4508);
        $display("test lanes done");
        end_of_test;
    end
endmodule
